// ---- rtl/sdvp_regs.vh ----
`ifndef SDVP_REGS_VH
`define SDVP_REGS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SDVP_OFS_MODE0    8'h00
`define SDVP_OFS_MODE1    8'h04
`define SDVP_OFS_COLSTART 8'h08
`define SDVP_OFS_GEOM     8'h0c
`define SDVP_OFS_PIXIN    8'h10
`define SDVP_OFS_STATUS   8'h14
// ----------------------------------------------------------------
// mode0 fields
// ----------------------------------------------------------------
`define SDVP_M0_SLAVE     0
`define SDVP_M0_PCLK_DR   1
`define SDVP_M0_PCLK_NEG  2
`define SDVP_M0_ROW_PULSE 3
`define SDVP_M0_ROW_POL   4
`define SDVP_M0_FRM_MODE  5
`define SDVP_M0_FRM_POL   7
`define SDVP_M0_TRG_LOW   8
`define SDVP_M0_DUMMY     12
// ----------------------------------------------------------------
// second video mode fields
// ----------------------------------------------------------------
`define SDVP_M1_FLOAT     0
`define SDVP_M1_SWITCH    1
`define SDVP_M1_UNUSED_Z  3
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define SDVP_MODE0_RST    32'h0000_0000
`define SDVP_GEOM_RST     32'h0008_0010
`define SDVP_FRM_LEVEL    2'h0
`define SDVP_FRM_PULSE    2'h1
`define SDVP_FRM_ODDEVEN  2'h2
`define SDVP_SW_STRAIGHT  2'h0
`define SDVP_SW_MSB10     2'h1
`define SDVP_SW_MSB9      2'h2
`define SDVP_ROW_LAT_BASE 12'h07c
`define SDVP_PULSE_MIN    4'h4
`endif

// ---- rtl/sdvp_video_port.v ----
// ----------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "sdvp_regs.vh"
module sdvp_video_port (
   input  wire        i_core_clk,    // master clock
   input  wire        i_rst,         // async reset, high
   input  wire        i_ce,          // clock enable
   input  wire [31:0] s_axi_awaddr,  // write address
   input  wire        s_axi_awvalid, // write address valid
   output wire        s_axi_awready, // write address ready
   input  wire [31:0] s_axi_wdata,   // write data
   input  wire [3:0]  s_axi_wstrb,   // byte enables
   input  wire        s_axi_wvalid,  // write data valid
   output wire        s_axi_wready,  // write data ready
   output wire [1:0]  s_axi_bresp,   // write response
   output wire        s_axi_bvalid,  // write response valid
   input  wire        s_axi_bready,  // write response ready
   input  wire [31:0] s_axi_araddr,  // read address
   input  wire        s_axi_arvalid, // read address valid
   output wire        s_axi_arready, // read address ready
   output wire [31:0] s_axi_rdata,   // read data
   output wire [1:0]  s_axi_rresp,   // read response
   output wire        s_axi_rvalid,  // read data valid
   input  wire        s_axi_rready,  // read data ready
   input  wire [11:0] i_pix_data,    // framer word
   output wire [11:0] o_d,           // pixel bus out
   output wire [11:0] o_d_oe,        // pixel bus drive enable
   output wire        o_pclk,        // pixel clock
   output wire        o_row_out,     // row sync out
   output wire        o_row_oe,      // row sync drive enable
   input  wire        i_row_in,      // row trigger pin
   output wire        o_frm_out,     // frame sync out
   output wire        o_frm_oe,      // frame sync drive enable
   input  wire        i_frm_in       // frame trigger pin
);
   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_ROW  = 2'h2;
   localparam ST_GAP  = 2'h3;

   reg [31:0] mode0_reg, mode1_reg, geom_reg;
   reg [7:0]  colstart_reg;
   reg [31:0] act0_reg, act1_reg, actg_reg;
   reg        awok_reg, wok_reg, bvalid_reg, rvalid_reg;
   reg [31:0] awaddr_reg, wdata_reg, rdata_reg;
   reg [3:0]  wstrb_reg;
   reg [1:0]  rresp_reg, bresp_reg;
   reg [1:0]  st_reg;
   reg        hclk_reg;
   reg [11:0] cnt_reg;
   reg [11:0] col_reg;
   reg [11:0] row_reg;
   reg [3:0]  dum_reg;
   reg        field_reg, frm_act_reg, frm_end_reg;
   reg [11:0] d_reg, d_oe_reg;
   reg        pclk_reg, rsync_reg, fsync_reg, sync_oe_reg;
   reg [3:0]  rpulse_reg, fpulse_reg;
   reg [2:0]  rs_reg, fs_reg;
   reg        rprev_reg, fprev_reg;

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   function [31:0] wmerge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  be;
      integer k;
      begin
         wmerge = old;
         for (k = 0; k < 4; k = k + 1)
            if (be[k])
               wmerge[k*8 +: 8] = nw[k*8 +: 8];
      end
   endfunction

   function [11:0] swmap;
      input [11:0] w;
      input [1:0]  m;
      begin
         case (m)
            `SDVP_SW_MSB10: swmap = {w[10:0], 1'b0};
            `SDVP_SW_MSB9:  swmap = {w[9:0], 2'h0};
            default:        swmap = w;
         endcase
      end
   endfunction

   // -------------------------------------------------------------
   // axi4-lite slave, answers two cycles after both write halves taken, one after a read
   // -------------------------------------------------------------
   wire wr_go = awok_reg && wok_reg && !bvalid_reg;
   wire wr_ok = awaddr_reg[7:0] == `SDVP_OFS_MODE0 ||
                awaddr_reg[7:0] == `SDVP_OFS_MODE1 ||
                awaddr_reg[7:0] == `SDVP_OFS_COLSTART ||
                awaddr_reg[7:0] == `SDVP_OFS_GEOM;
   // readies drop while frozen, so nothing is offered that is not taken
   assign s_axi_awready = i_ce && !awok_reg && !bvalid_reg;
   assign s_axi_wready  = i_ce && !wok_reg && !bvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = i_ce && !rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         awok_reg <= 1'b0;
         wok_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= 2'h0;
         awaddr_reg <= 32'h0000_0000;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         mode0_reg <= `SDVP_MODE0_RST;
         mode1_reg <= 32'h0000_0000;
         colstart_reg <= 8'h00;
         geom_reg <= `SDVP_GEOM_RST;
      end else if (i_ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awok_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wok_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            awok_reg <= 1'b0;
            wok_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? 2'h0 : 2'h2;
            case (awaddr_reg[7:0])
               `SDVP_OFS_MODE0:
                  mode0_reg <= wmerge(mode0_reg, wdata_reg, wstrb_reg);
               `SDVP_OFS_MODE1:
                  mode1_reg <= wmerge(mode1_reg, wdata_reg, wstrb_reg);
               `SDVP_OFS_COLSTART:
                  if (wstrb_reg[0])
                     colstart_reg <= wdata_reg[7:0];
               `SDVP_OFS_GEOM:
                  geom_reg <= wmerge(geom_reg, wdata_reg, wstrb_reg);
               default: ;
            endcase
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
         if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= 2'h0;
            case (s_axi_araddr[7:0])
               `SDVP_OFS_MODE0:    rdata_reg <= mode0_reg;
               `SDVP_OFS_MODE1:    rdata_reg <= mode1_reg;
               `SDVP_OFS_COLSTART: rdata_reg <= {24'h000000, colstart_reg};
               `SDVP_OFS_GEOM:     rdata_reg <= geom_reg;
               `SDVP_OFS_STATUS:
                  rdata_reg <= {12'h000, row_reg, 4'h0, st_reg,
                                field_reg, frm_act_reg};
               default: begin
                  rdata_reg <= 32'h0000_0000;
                  rresp_reg <= 2'h2;
               end
            endcase
         end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------
   // trigger synchronisers, all on the master clock
   // -------------------------------------------------------------
   wire trg_low = act0_reg[`SDVP_M0_TRG_LOW];
   wire row_lvl = rs_reg[1] ^ trg_low;
   wire frm_lvl = fs_reg[1] ^ trg_low;
   // a change counts only once the second and third stages agree
   wire row_new = (rs_reg[1] == rs_reg[2]) && row_lvl;
   wire frm_new = (fs_reg[1] == fs_reg[2]) && frm_lvl;
   wire row_trg = row_new && !rprev_reg;
   wire frm_trg = frm_new && !fprev_reg;

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         rs_reg <= 3'h0;
         fs_reg <= 3'h0;
         rprev_reg <= 1'b0;
         fprev_reg <= 1'b0;
      end else if (i_ce) begin
         rs_reg <= {rs_reg[1:0], i_row_in};
         fs_reg <= {fs_reg[1:0], i_frm_in};
         rprev_reg <= row_new;
         fprev_reg <= frm_new;
      end
   end

   // -------------------------------------------------------------
   // timing and framing
   // -------------------------------------------------------------
   wire        slave  = act0_reg[`SDVP_M0_SLAVE];
   wire        pdr    = act0_reg[`SDVP_M0_PCLK_DR];
   wire        pneg   = act0_reg[`SDVP_M0_PCLK_NEG];
   wire        rpulse = act0_reg[`SDVP_M0_ROW_PULSE];
   wire        rpol   = act0_reg[`SDVP_M0_ROW_POL];
   wire [1:0]  fmode  = act0_reg[`SDVP_M0_FRM_MODE +: 2];
   wire        fpol   = act0_reg[`SDVP_M0_FRM_POL];
   wire [3:0]  ndum   = act0_reg[`SDVP_M0_DUMMY +: 4];
   wire [11:0] ncol   = actg_reg[11:0];
   wire [11:0] nrow   = actg_reg[27:16];
   wire [11:0] lat    = `SDVP_ROW_LAT_BASE + {4'h0, colstart_reg};
   wire        hedge  = hclk_reg;      // data edge of the hclk cycle
   wire        last_col = col_reg == ncol - 12'h001;
   wire        last_row = row_reg == nrow - 12'h001;
   wire        in_row = st_reg == ST_ROW;
   wire        real_pix = in_row && dum_reg == 4'h0;
   wire [1:0]  sw     = act1_reg[`SDVP_M1_SWITCH +: 2];
   wire [11:0] unused = sw == `SDVP_SW_MSB10 ? 12'h001 :
                        sw == `SDVP_SW_MSB9  ? 12'h003 : 12'h000;

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         act0_reg <= `SDVP_MODE0_RST;
         act1_reg <= 32'h0000_0000;
         actg_reg <= `SDVP_GEOM_RST;
         st_reg <= ST_IDLE;
         // starts high so the pixel clock toggles from the first edge
         hclk_reg <= 1'b1;
         cnt_reg <= 12'h000;
         col_reg <= 12'h000;
         row_reg <= 12'h000;
         dum_reg <= 4'h0;
         field_reg <= 1'b0;
         frm_act_reg <= 1'b0;
         frm_end_reg <= 1'b0;
      end else if (i_ce) begin
         hclk_reg <= ~hclk_reg;
         frm_end_reg <= 1'b0;
         case (st_reg)
            ST_IDLE: begin
               // mode and geometry settings load only here, between frames; colstart_reg acts at once
               act0_reg <= mode0_reg;
               act1_reg <= mode1_reg;
               actg_reg <= geom_reg;
               if (!mode0_reg[`SDVP_M0_SLAVE] && hedge) begin
                  st_reg <= ST_ROW;
                  frm_act_reg <= 1'b1;
                  row_reg <= 12'h000;
                  col_reg <= 12'h000;
                  dum_reg <= mode0_reg[`SDVP_M0_DUMMY +: 4];
               end else if (mode0_reg[`SDVP_M0_SLAVE] && row_trg) begin
                  st_reg <= ST_WAIT;
                  cnt_reg <= 12'h000;
               end
            end
            ST_WAIT: begin
               // slave latency counted from the trigger edge; the
               // synchroniser and the detector eat the other clocks
               if (cnt_reg >= lat - 12'h005) begin
                  st_reg <= ST_ROW;
                  col_reg <= 12'h000;
                  dum_reg <= ndum;
               end else begin
                  cnt_reg <= cnt_reg + 12'h001;
               end
            end
            ST_ROW: begin
               if (!hedge) begin
                  st_reg <= ST_ROW;
               end else if (dum_reg != 4'h0) begin
                  dum_reg <= dum_reg - 4'h1;
               end else if (last_col) begin
                  st_reg <= ST_GAP;
                  cnt_reg <= 12'h000;
                  if (last_row) begin
                     frm_act_reg <= 1'b0;
                     frm_end_reg <= 1'b1;
                     field_reg <= ~field_reg;
                  end
                  row_reg <= row_reg + 12'h001;
               end else begin
                  col_reg <= col_reg + 12'h001;
               end
            end
            ST_GAP: begin
               // master frames keep the full row gap before idling
               if (!frm_act_reg && (slave || cnt_reg == 12'h00f)) begin
                  st_reg <= ST_IDLE;
               end else if (slave && row_trg) begin
                  st_reg <= ST_WAIT;
                  cnt_reg <= 12'h000;
               end else if (!slave && cnt_reg == 12'h00f && hedge) begin
                  st_reg <= ST_ROW;
                  col_reg <= 12'h000;
                  dum_reg <= ndum;
               end else if (cnt_reg != 12'h00f) begin
                  cnt_reg <= cnt_reg + 12'h001;
               end
            end
            default: st_reg <= ST_IDLE;
         endcase
         // the frame trigger may land while a row is already pending
         if (slave && frm_trg) begin
            row_reg <= 12'h000;
            frm_act_reg <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------
   // pin formatting
   // -------------------------------------------------------------
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         d_reg <= 12'h000;
         d_oe_reg <= 12'hfff;
         pclk_reg <= 1'b1;
         rsync_reg <= 1'b0;
         fsync_reg <= 1'b0;
         sync_oe_reg <= 1'b1;
         rpulse_reg <= 4'h0;
         fpulse_reg <= 4'h0;
      end else if (i_ce) begin
         sync_oe_reg <= !slave;
         if (act1_reg[`SDVP_M1_FLOAT])
            d_oe_reg <= 12'h000;
         else if (act1_reg[`SDVP_M1_UNUSED_Z])
            d_oe_reg <= ~unused;
         else
            d_oe_reg <= 12'hfff;
         if (in_row)
            d_reg <= real_pix ? swmap(i_pix_data, sw) : 12'h000;
         // free: pclk rises as data changes, falls instead if negedge set
         if (!pdr)
            pclk_reg <= ~hclk_reg ^ pneg;
         else
            pclk_reg <= (in_row && hclk_reg) ^ pneg;
         if (st_reg == ST_ROW && last_col && dum_reg == 4'h0 && hedge)
            rpulse_reg <= `SDVP_PULSE_MIN + `SDVP_PULSE_MIN;
         else if (rpulse_reg != 4'h0)
            rpulse_reg <= rpulse_reg - 4'h1;
         if (frm_end_reg)
            fpulse_reg <= `SDVP_PULSE_MIN + `SDVP_PULSE_MIN;
         else if (fpulse_reg != 4'h0)
            fpulse_reg <= fpulse_reg - 4'h1;
         if (rpulse)
            rsync_reg <= (rpulse_reg != 4'h0) ^ ~rpol;
         else
            rsync_reg <= in_row ^ rpol;
         case (fmode)
            `SDVP_FRM_PULSE:
               fsync_reg <= (fpulse_reg != 4'h0) ^ ~fpol;
            `SDVP_FRM_ODDEVEN:
               fsync_reg <= field_reg ^ fpol;
            default:
               fsync_reg <= frm_act_reg ^ fpol;
         endcase
      end
   end

   assign o_d       = d_reg;
   assign o_d_oe    = d_oe_reg;
   assign o_pclk    = pclk_reg;
   assign o_row_out = rsync_reg;
   assign o_row_oe  = sync_oe_reg;
   assign o_frm_out = fsync_reg;
   assign o_frm_oe  = sync_oe_reg;
endmodule // sdvp_video_port

// ---- testbench/sdvp_video_port_chk.sv ----
`timescale 1ns/1ps
// ----
// port checker
// ----
module sdvp_video_port_chk (
   input wire        i_core_clk,    // clock
   input wire        i_rst,         // reset
   input wire        i_ce,          // enable
   input wire        s_axi_awvalid, // aw valid
   input wire        s_axi_awready, // aw ready
   input wire        s_axi_wvalid,  // w valid
   input wire        s_axi_wready,  // w ready
   input wire        s_axi_bvalid,  // b valid
   input wire        s_axi_arvalid, // ar valid
   input wire        s_axi_arready, // ar ready
   input wire [31:0] s_axi_rdata,   // read data
   input wire        s_axi_rvalid,  // r valid
   input wire        s_axi_rready,  // r ready
   input wire [11:0] o_d,           // pixel bus
   input wire [11:0] o_d_oe,        // bus enables
   input wire        o_pclk,        // pixel clock
   input wire        o_row_out,     // row sync
   input wire        o_row_oe,      // row enable
   input wire        o_frm_out,     // frame sync
   input wire        o_frm_oe       // frame enable
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);

   a_sync_oe_pair: assert property (o_row_oe == o_frm_oe)
      else $error("sync drive enables disagree");
   a_row_width: assert property
      (o_row_oe && $changed(o_row_out) |=> $stable(o_row_out)[*5])
      else $error("row sync level too short");
   a_frm_width: assert property
      (o_frm_oe && $changed(o_frm_out) |=> $stable(o_frm_out)[*7])
      else $error("frame sync level too short");
   a_data_edge: assert property
      (o_row_oe && $changed(o_d) && $stable(o_d_oe) |-> $changed(o_pclk))
      else $error("pixel data moved off the clock edge");
   a_ce_freeze: assert property
      (!i_ce |=> $stable(o_d) && $stable(o_pclk) && $stable(o_row_out))
      else $error("outputs moved while clock enable low");
   a_write_answer: assert property
      (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
       |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property
      (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   a_read_hold: assert property
      (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");

   c_slave: cover property (!o_row_oe);
   c_frame: cover property (o_frm_oe && $fell(o_frm_out));
   c_freeze: cover property (!i_ce);
endmodule // sdvp_video_port_chk

bind sdvp_video_port sdvp_video_port_chk u_chk (.*);

// ---- testbench/sdvp_video_port_tb.sv ----
`timescale 1ns/1ps
`include "sdvp_regs.vh"
module sdvp_video_port_tb;
   reg         i_core_clk = 1'b0;
   reg         i_rst = 1'b1;
   reg         i_ce = 1'b1;
   reg  [31:0] s_axi_awaddr = 32'h0;
   reg  [31:0] s_axi_wdata = 32'h0;
   reg  [31:0] s_axi_araddr = 32'h0;
   reg  [3:0]  s_axi_wstrb = 4'hf;
   reg         s_axi_awvalid = 1'b0;
   reg         s_axi_wvalid = 1'b0;
   reg         s_axi_bready = 1'b0;
   reg         s_axi_arvalid = 1'b0;
   reg         s_axi_rready = 1'b0;
   reg  [11:0] i_pix_data = 12'h5a3;
   reg         fire = 1'b0;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire        s_axi_rvalid, o_pclk, o_row_out, o_row_oe, o_frm_out, o_frm_oe;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [11:0] o_d, o_d_oe;
   wire        row_trg, frm_trg;
   wire [15:0] npix;
   wire        i_row_in = o_row_oe ? o_row_out : row_trg;
   wire        i_frm_in = o_frm_oe ? o_frm_out : frm_trg;
   integer     miscompares = 0;
   integer     n_tests = 0;

   sdvp_video_port uut (.*);
   sdvp_video_sink u_sink (.i_pclk(o_pclk), .i_row(o_row_out),
      .i_fire(fire), .o_row_trg(row_trg), .o_frm_trg(frm_trg),
      .o_npix(npix));

   initial begin
      forever #20 i_core_clk = ~i_core_clk;
   end

   // ----
   // shared tasks
   // ----
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   task conclude;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, miscompares);
         if (miscompares == 0 && n_tests > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   // a hung handshake is a mismatch and ends the run
   task tmo;
      begin
         chk(32'h0, 32'h1);
         conclude;
      end
   endtask

   task axw(input [7:0] a, input [31:0] d);
      reg ta, tw, bk;
      reg [1:0] br;
      integer n;
      begin
         @(posedge i_core_clk);
         s_axi_awaddr <= {24'h0, a};
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         bk = 1'b0;
         for (n = 0; n < 50 && !bk; n = n + 1) begin
            @(negedge i_core_clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            bk = s_axi_bvalid;
            br = s_axi_bresp;
            @(posedge i_core_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (bk) s_axi_bready <= 1'b0;
         end
         if (!bk) tmo;
         chk(br, 2'h0);
      end
   endtask

   task axr(input [7:0] a, input [31:0] e, input [1:0] er);
      reg ta, rk;
      reg [31:0] rd;
      reg [1:0] rr;
      integer n;
      begin
         @(posedge i_core_clk);
         s_axi_araddr <= {24'h0, a};
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         rk = 1'b0;
         for (n = 0; n < 50 && !rk; n = n + 1) begin
            @(negedge i_core_clk);
            ta = s_axi_arvalid & s_axi_arready;
            rk = s_axi_rvalid;
            rd = s_axi_rdata;
            rr = s_axi_rresp;
            @(posedge i_core_clk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (rk) s_axi_rready <= 1'b0;
         end
         if (!rk) tmo;
         chk(rd, e);
         chk(rr, er);
      end
   endtask

   // waits for the sync to reach v, then counts clocks until it leaves v
   task pulse_w(input sel, input v, output integer w);
      integer n;
      begin
         n = 0;
         while ((sel ? o_frm_out : o_row_out) !== v && n < 3000) begin
            @(negedge i_core_clk);
            n = n + 1;
         end
         w = 0;
         while ((sel ? o_frm_out : o_row_out) === v && w < 3000) begin
            @(negedge i_core_clk);
            w = w + 1;
         end
         if (n == 3000 || w == 3000) tmo;
      end
   endtask

   // new mode and geometry settings only land at a frame boundary, so let frames pass
   task settle;
      integer w;
      begin
         repeat (8) pulse_w(1'b0, 1'b0, w);
         repeat (2) @(negedge i_core_clk);
      end
   endtask

   // ----
   // scenarios
   // ----
   task t_reset;
      integer i;
      reg p;
      begin
         @(negedge i_core_clk);
         chk(o_row_oe, 1'b1);
         chk(o_d_oe, 12'hfff);
         p = o_pclk;
         for (i = 0; i < 4; i = i + 1) begin
            @(negedge i_core_clk);
            chk(o_pclk, !p);
            p = o_pclk;
         end
         axr(`SDVP_OFS_MODE0, `SDVP_MODE0_RST, 2'h0);
         axr(`SDVP_OFS_GEOM, `SDVP_GEOM_RST, 2'h0);
         axr(8'h40, 32'h0, 2'h2);
         axw(`SDVP_OFS_COLSTART, 32'ha);
         axr(`SDVP_OFS_COLSTART, 32'ha, 2'h0);
         $display("test reset done");
      end
   endtask

   task t_master;
      integer w, i;
      begin
         pulse_w(1'b0, 1'b0, w);
         repeat (2) @(negedge i_core_clk);
         chk(o_d, i_pix_data);
         pulse_w(1'b0, 1'b1, w);
         repeat (2) @(negedge i_core_clk);
         chk(npix, 16'h10);
         @(posedge i_core_clk);
         i_ce <= 1'b0;
         repeat (20) @(posedge i_core_clk);
         i_ce <= 1'b1;
         axw(`SDVP_OFS_GEOM, 32'h0002_0004);
         axw(`SDVP_OFS_MODE0, 32'h0000_f000);
         for (i = 0; i < 30 && npix !== 16'h13; i = i + 1) begin
            pulse_w(1'b0, 1'b1, w);
            repeat (2) @(negedge i_core_clk);
         end
         chk(npix, 16'h13);
         $display("test master done");
      end
   endtask

   task t_map;
      begin
         axw(`SDVP_OFS_MODE0, 32'h0);
         axw(`SDVP_OFS_MODE1, 32'h2);
         settle;
         chk(o_d[11:1], i_pix_data[10:0]);
         axw(`SDVP_OFS_MODE1, 32'hc);
         settle;
         chk(o_d[11:2], i_pix_data[9:0]);
         chk(o_d_oe, 12'hffc);
         axw(`SDVP_OFS_MODE1, 32'h1);
         settle;
         chk(o_d_oe, 12'h000);
         axw(`SDVP_OFS_MODE1, 32'h0);
         $display("test map done");
      end
   endtask

   task t_pulse;
      integer w, i;
      begin
         axw(`SDVP_OFS_MODE0, 32'h3a);
         w = 0;
         for (i = 0; i < 30 && w != 8; i = i + 1)
            pulse_w(1'b1, 1'b0, w);
         chk(w, 32'h8);
         pulse_w(1'b0, 1'b1, w);
         chk(w, 32'h8);
         $display("test pulse done");
      end
   endtask

   task t_slave;
      integer n;
      begin
         axw(`SDVP_OFS_MODE0, 32'h1);
         for (n = 0; n < 3000 && o_row_oe !== 1'b0; n = n + 1)
            @(negedge i_core_clk);
         chk(o_frm_oe, 1'b0);
         @(posedge i_core_clk);
         i_pix_data <= 12'h3c6;
         repeat (200) @(posedge i_core_clk);
         chk(o_d === 12'h3c6, 1'b0);
         fire <= 1'b1;
         for (n = 0; n < 100 && row_trg !== 1'b1; n = n + 1)
            @(posedge i_core_clk);
         fire <= 1'b0;
         for (n = 0; n < 400 && o_d !== 12'h3c6; n = n + 1)
            @(negedge i_core_clk);
         chk(n >= 130 && n <= 140, 1'b1);
         $display("test slave done");
      end
   endtask

   initial begin
      repeat (2) @(posedge i_core_clk);
      i_rst <= 1'b0;
      t_reset;
      t_master;
      t_map;
      t_pulse;
      t_slave;
      conclude;
   end
endmodule // sdvp_video_port_tb

// ---- testbench/sdvp_video_sink.sv ----
`timescale 1ns/1ps
// ----
// video processor stand-in
// ----
module sdvp_video_sink (
   input  wire        i_pclk,    // pixel clock
   input  wire        i_row,     // row sync, active high
   input  wire        i_fire,    // ask for one row trigger
   output reg         o_row_trg, // row trigger pin
   output reg         o_frm_trg, // frame trigger pin
   output reg  [15:0] o_npix     // pixels in the last row
);
   reg        lclk;
   reg [15:0] cnt;

   initial begin
      lclk = 1'b0;
      cnt = 16'h0;
      o_npix = 16'h0;
      o_row_trg = 1'b0;
      o_frm_trg = 1'b0;
      #7;
      forever #160 lclk = ~lclk;
   end

   // sampled on the fall, away from the data change on the rise
   always @(negedge i_pclk) begin
      if (i_row) begin
         cnt <= cnt + 16'h1;
      end else if (cnt != 16'h0) begin
         o_npix <= cnt;
         cnt <= 16'h0;
      end
   end

   // each trigger lasts one link period, eight core clocks
   always @(posedge lclk) begin
      o_row_trg <= i_fire;
      o_frm_trg <= o_row_trg;
   end
endmodule // sdvp_video_sink
